//--- sctl_assertions.sv
// link checker for the controller and register block
module sctl_assertions
    import sctl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        irq_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // a read answer counts only while the request still stands
    wire rd_ack = ack && req && !wr;
    property p_take; req && !ack |=> ack; endproperty
    property p_pulse; ack |=> !ack; endproperty
    property p_drop; ack |=> !req; endproperty
    property p_align; req |-> addr[1:0] == 2'h0; endproperty
    property p_hold; req && !ack |=> $stable({wr, addr, wdata}); endproperty
    property p_dir; rd_ack && addr == PIN_DIR_ADDR |-> rdata[31:6] == 26'h0; endproperty
    property p_ctl; rd_ack && addr == CNT_CTL_ADDR |-> rdata[31:2] == 30'h0; endproperty
    property p_pend; rd_ack && addr == PEND_ADDR |-> (rdata & 32'hfc0e_070f) == 32'h0; endproperty
    property p_mask; ack && wr && addr == MASK_ADDR && wdata == 32'h0 |-> ##[0:1] irq_n; endproperty
    a_take: assert property (p_take) else $error("request not answered");
    a_pulse: assert property (p_pulse) else $error("ack too long");
    a_drop: assert property (p_drop) else $error("req kept after ack");
    a_align: assert property (p_align) else $error("unaligned word");
    a_hold: assert property (p_hold) else $error("request changed");
    a_dir: assert property (p_dir) else $error("direction high bits set");
    a_ctl: assert property (p_ctl) else $error("control high bits set");
    a_pend: assert property (p_pend) else $error("reserved cause bit set");
    a_mask: assert property (p_mask) else $error("masked irq still low");
    c_wr: cover property (ack && wr);
    c_rd: cover property (rd_ack);
    c_irq: cover property (!irq_n);
endmodule : sctl_assertions

//--- sctl_dev.sv
// register block end: rom timing, pin port, timer/counter and interrupt cause logic
//
// Operation
// - software uses only whole 32-bit word accesses
// - first strobe delay field, n gives n+1
// - three strobe gap fields, n gives n+1
// - block ack delay, n+1 cycles, resets 0x3f
// - window size code picks banks 0/1 size
// - software keeps ack delay consistent; unchecked
// - output pins driven from output value register
// - direction bit 0 output, 1 input; reset inputs
// - pin sense reads present level of pins
// - reload value n makes unit count n
// - control bit0 enable, bit1 timer mode
// - cause bits read 1 while source asserted
// - writing 0 clears internal cause bit
// - pin cause bits read-only, cleared at source
// - fixed cause bit assignment per source
// - mask bit 0 disables matching source
// - test register writes set cause bits
//
// Our own choice: the APB register port.
module sctl_dev
    import sctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    sctl_if.dev              link,
    input  wire logic [5:0]  pin_in,
    output logic      [5:0]  pin_out,
    output logic      [5:0]  pin_oe,
    input  wire logic        count_event,
    input  wire logic [1:0]  io_channel_dma_done_irq,
    input  wire logic        parport_dma_done_irq,
    input  wire logic        parport_reset_irq,
    input  wire logic        parport_write_irq,
    input  wire logic        parport_read_irq,
    input  wire logic [2:0]  byte_match_irq,
    input  wire logic [5:0]  pin_irq,
    input  wire logic        rom_req,
    input  wire logic [24:0] rom_addr,
    output logic      [2:0]  boot_bank_select_n,
    output logic             read_data_strobe_n,
    output logic             rom_block_ack,
    output logic             rom_busy
);
    import sctl_pkg::*;

    logic [23:0] rom_cfg_ff;
    logic [5:0]  pin_val_ff;
    logic [5:0]  pin_dir_ff;
    logic [5:0]  pin_out_ff;
    logic [5:0]  pin_oe_ff;
    logic [23:0] reload_ff;
    logic [1:0]  cnt_ctl_ff;
    logic [23:0] cnt_ff;
    logic [25:0] pend_ff;
    logic [25:0] mask_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        irq_n_ff;
    logic [31:0] nxt_rdata;
    logic [25:0] nxt_pend;
    logic [25:0] events;

    // a request is taken once; the ack pulse blocks a second take of the same one
    wire take = link.req && !ack_ff;
    wire wr   = take && link.wr;

    // address decode; only whole aligned words are decoded, the bus is word-only
    wire hit_rom    = (link.addr == ROM_CFG_ADDR);
    wire hit_pval   = (link.addr == PIN_VAL_ADDR);
    wire hit_pdir   = (link.addr == PIN_DIR_ADDR);
    wire hit_reload = (link.addr == RELOAD_ADDR);
    wire hit_ctl    = (link.addr == CNT_CTL_ADDR);
    wire hit_pend   = (link.addr == PEND_ADDR);
    wire hit_mask   = (link.addr == MASK_ADDR);
    wire hit_sense  = (link.addr == SENSE_ADDR);
    wire hit_test   = (link.addr == TEST_SET_ADDR);

    // timer mode counts clocks, counter mode counts external events
    wire         cnt_en   = cnt_ctl_ff[CTL_EN_BIT];
    wire         cnt_tick = cnt_en && (cnt_ctl_ff[CTL_MODE_BIT] || count_event);
    wire  [23:0] cnt_inc  = cnt_ff + 24'h00_0001;
    wire         tmr_hit  = cnt_tick && (cnt_inc == reload_ff);

    // pin sources are live levels, never stored, so writes cannot touch them
    wire  [25:0] pin_cause = 26'(pin_irq) << IRQ_PIN_LSB;
    wire  [25:0] cause     = pend_ff | pin_cause;
    wire  [25:0] clr_keep  = (wr && hit_pend) ? (link.wdata[25:0] | ~IRQ_INT_BITS)
                                              : 26'h3ff_ffff;
    wire  [25:0] test_set  = (wr && hit_test) ? (link.wdata[25:0] & IRQ_INT_BITS)
                                              : 26'h000_0000;

    // source placement within the cause word
    always_comb begin
        events                                  = 26'h000_0000;
        events[IRQ_TIMER_BIT]                   = tmr_hit;
        events[IRQ_IODMA_LSB +: 2]              = io_channel_dma_done_irq;
        events[IRQ_PPDMA_BIT]                   = parport_dma_done_irq;
        events[IRQ_PPRST_BIT]                   = parport_reset_irq;
        events[IRQ_PPWR_BIT]                    = parport_write_irq;
        events[IRQ_PPRD_BIT]                    = parport_read_irq;
        events[IRQ_MATCH_LSB +: 3]              = byte_match_irq;
    end

    // set terms are or-ed in last so an event beats a clear in the same cycle
    assign nxt_pend = (pend_ff & clr_keep) | events | test_set;

    // read data selection
    always_comb begin
        if (hit_rom) begin
            nxt_rdata = {8'h00, rom_cfg_ff};
        end else if (hit_pval) begin
            nxt_rdata = {26'h000_0000, pin_val_ff};
        end else if (hit_pdir) begin
            nxt_rdata = {26'h000_0000, pin_dir_ff};
        end else if (hit_reload) begin
            nxt_rdata = {8'h00, reload_ff};
        end else if (hit_ctl) begin
            nxt_rdata = {30'h0000_0000, cnt_ctl_ff};
        end else if (hit_pend) begin
            nxt_rdata = {6'h00, cause};
        end else if (hit_mask) begin
            nxt_rdata = {6'h00, mask_ff};
        end else if (hit_sense) begin
            nxt_rdata = {26'h000_0000, pin_in};
        end else begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    // link answer: one ack pulse the cycle after the take, read data with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= take;
            if (take) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // software-written configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_cfg_ff <= ROM_CFG_RST;
            pin_val_ff <= PIN_VAL_RST;
            pin_dir_ff <= PIN_DIR_RST;
            reload_ff  <= RELOAD_RST;
            cnt_ctl_ff <= CNT_CTL_RST;
            mask_ff    <= MASK_RST;
        end else if (wr) begin
            if (hit_rom) begin
                rom_cfg_ff <= link.wdata[23:0];
            end
            if (hit_pval) begin
                pin_val_ff <= link.wdata[5:0];
            end
            if (hit_pdir) begin
                pin_dir_ff <= link.wdata[5:0];
            end
            if (hit_reload) begin
                reload_ff <= link.wdata[23:0];
            end
            if (hit_ctl) begin
                cnt_ctl_ff <= link.wdata[1:0];
            end
            if (hit_mask) begin
                mask_ff <= link.wdata[25:0];
            end
        end
    end

    // timer/counter; restarts from zero after each hit, cleared while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 24'h00_0000;
        end else if (!cnt_en || tmr_hit) begin
            cnt_ff <= 24'h00_0000;
        end else if (cnt_tick) begin
            cnt_ff <= cnt_inc;
        end
    end

    // sticky internal causes and the masked interrupt line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff  <= PEND_RST;
            irq_n_ff <= 1'b1;
        end else begin
            pend_ff  <= nxt_pend;
            irq_n_ff <= ~|(cause & mask_ff);
        end
    end

    // pin drive is registered so the pins never glitch on a write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_ff <= PIN_VAL_RST;
            pin_oe_ff  <= ~PIN_DIR_RST;
        end else begin
            pin_out_ff <= pin_val_ff;
            pin_oe_ff  <= ~pin_dir_ff;
        end
    end

    // rom sequencer; the ack delay is used as programmed, never checked
    sctl_rom_seq u_rom_seq (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (rom_req),
        .addr_off   (rom_addr),
        .cfg        (rom_cfg_ff),
        .bank_sel_n (boot_bank_select_n),
        .strobe_n   (read_data_strobe_n),
        .block_ack  (rom_block_ack),
        .busy       (rom_busy)
    );

    assign link.ack   = ack_ff;
    assign link.rdata = rdata_ff;
    assign link.irq_n = irq_n_ff;
    assign pin_out    = pin_out_ff;
    assign pin_oe     = pin_oe_ff;
endmodule : sctl_dev

//--- sctl_host.sv
// controller end: apb-programmed engine that issues word accesses on the link
module sctl_host
    import sctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    sctl_if.host             link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import sctl_pkg::*;

    logic [31:0] cmd_addr_ff;
    logic [31:0] cmd_wdata_ff;
    logic [31:0] rd_ff;
    logic        req_ff;
    logic        wr_ff;
    logic [31:0] addr_ff;
    logic [31:0] wdata_ff;
    logic        irq_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] nxt_prdata;

    wire setup    = psel && !penable;
    wire hit_addr = (paddr == HOST_ADDR_OFS);
    wire hit_wdat = (paddr == HOST_WDATA_OFS);
    wire hit_ctrl = (paddr == HOST_CTRL_OFS);
    wire hit_stat = (paddr == HOST_STAT_OFS);
    wire hit_rdat = (paddr == HOST_RDATA_OFS);
    wire hit_any  = hit_addr || hit_wdat || hit_ctrl || hit_stat || hit_rdat;
    wire wr_acc   = psel && penable && pready_ff && pwrite;
    // a go while a transfer is open is dropped; software polls busy first
    wire go       = wr_acc && hit_ctrl && pwdata[HOST_GO_BIT] && !req_ff;

    always_comb begin
        if (hit_addr) begin
            nxt_prdata = cmd_addr_ff;
        end else if (hit_wdat) begin
            nxt_prdata = cmd_wdata_ff;
        end else if (hit_stat) begin
            nxt_prdata = {30'h0000_0000, irq_ff, req_ff};
        end else if (hit_rdat) begin
            nxt_prdata = rd_ff;
        end else begin
            nxt_prdata = 32'h0000_0000;
        end
    end

    // apb slave: always answers in the first access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !hit_any;
            if (setup) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // command registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_addr_ff  <= 32'h0000_0000;
            cmd_wdata_ff <= 32'h0000_0000;
        end else if (wr_acc) begin
            if (hit_addr) begin
                cmd_addr_ff <= {pwdata[31:2], 2'h0};
            end
            if (hit_wdat) begin
                cmd_wdata_ff <= pwdata;
            end
        end
    end

    // link request held until the device acks; always a whole word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ff   <= 1'b0;
            wr_ff    <= 1'b0;
            addr_ff  <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            rd_ff    <= 32'h0000_0000;
            irq_ff   <= 1'b0;
        end else begin
            irq_ff <= ~link.irq_n;
            if (req_ff && link.ack) begin
                req_ff <= 1'b0;
                if (!wr_ff) begin
                    rd_ff <= link.rdata;
                end
            end else if (go) begin
                req_ff   <= 1'b1;
                wr_ff    <= pwdata[HOST_WR_BIT];
                addr_ff  <= cmd_addr_ff;
                wdata_ff <= cmd_wdata_ff;
            end
        end
    end

    assign link.req   = req_ff;
    assign link.wr    = wr_ff;
    assign link.addr  = addr_ff;
    assign link.wdata = wdata_ff;
    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
endmodule : sctl_host

//--- sctl_if.sv
// word-wide register link between the controller and the register block
interface sctl_if;
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        irq_n;
    modport dev  (input req, wr, addr, wdata, output rdata, ack, irq_n);
    modport host (output req, wr, addr, wdata, input rdata, ack, irq_n);
endinterface : sctl_if

//--- sctl_pkg.sv
// shared constants for the system control register block and its controller
package sctl_pkg;
    // device register word addresses
    localparam logic [31:0] ROM_CFG_ADDR   = 32'h1d00_0000;
    localparam logic [31:0] PIN_VAL_ADDR   = 32'h1d00_0040;
    localparam logic [31:0] PIN_DIR_ADDR   = 32'h1d00_0044;
    localparam logic [31:0] RELOAD_ADDR    = 32'h1d00_0048;
    localparam logic [31:0] CNT_CTL_ADDR   = 32'h1d00_004c;
    localparam logic [31:0] PEND_ADDR      = 32'h1d00_0050;
    localparam logic [31:0] MASK_ADDR      = 32'h1d00_0054;
    localparam logic [31:0] SENSE_ADDR     = 32'h1d00_005c;
    localparam logic [31:0] TEST_SET_ADDR  = 32'h1d00_0060;
    // rom timing field positions
    localparam int FIRST_LSB = 0;
    localparam int STROBE_GAP_ONE_LSB  = 4;
    localparam int ACK_LSB   = 16;
    localparam int SIZE_LSB  = 22;
    // reset values
    localparam logic [23:0] ROM_CFG_RST = 24'hff_ffff;
    localparam logic [5:0]  PIN_VAL_RST = 6'h00;
    localparam logic [5:0]  PIN_DIR_RST = 6'h3f;
    localparam logic [23:0] RELOAD_RST  = 24'h00_0000;
    localparam logic [1:0]  CNT_CTL_RST = 2'h0;
    localparam logic [25:0] MASK_RST    = 26'h000_0000;
    localparam logic [25:0] PEND_RST    = 26'h000_0000;
    // count control bits
    localparam int CTL_EN_BIT   = 0;
    localparam int CTL_MODE_BIT = 1;
    // cause / mask bit positions
    localparam int IRQ_TIMER_BIT  = 4;
    localparam int IRQ_IODMA_LSB  = 5;
    localparam int IRQ_PPDMA_BIT  = 7;
    localparam int IRQ_PPRST_BIT  = 11;
    localparam int IRQ_PPWR_BIT   = 12;
    localparam int IRQ_PPRD_BIT   = 13;
    localparam int IRQ_MATCH_LSB  = 14;
    localparam int IRQ_PIN_LSB    = 20;
    localparam logic [25:0] IRQ_INT_BITS = 26'h001_f8f0;
    // rom bank windows
    localparam logic [24:0] ROM_MAX_WIN   = 25'h080_0000;
    localparam logic [24:0] ROM_FIXED_WIN = 25'h040_0000;
    // controller apb register offsets
    localparam logic [11:0] HOST_ADDR_OFS  = 12'h000;
    localparam logic [11:0] HOST_WDATA_OFS = 12'h004;
    localparam logic [11:0] HOST_CTRL_OFS  = 12'h008;
    localparam logic [11:0] HOST_STAT_OFS  = 12'h00c;
    localparam logic [11:0] HOST_RDATA_OFS = 12'h010;
    localparam int HOST_GO_BIT   = 0;
    localparam int HOST_WR_BIT   = 1;
    localparam int HOST_BUSY_BIT = 0;
    localparam int HOST_IRQ_BIT  = 1;
endpackage : sctl_pkg

//--- sctl_rom_seq.sv
// boot rom bank select, read strobe and block acknowledge sequencer
module sctl_rom_seq
    import sctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [24:0] addr_off,
    input  wire logic [23:0] cfg,
    output logic      [2:0]  bank_sel_n,
    output logic             strobe_n,
    output logic             block_ack,
    output logic             busy
);
    typedef enum logic {SEQ_IDLE, SEQ_RUN} sctl_seq_t;

    // which bank an offset falls in, one-hot; zero when outside all banks
    function automatic logic [2:0] bank_decode(input logic [24:0] off, input logic [1:0] size);
        logic [24:0] win;
        win = ROM_MAX_WIN >> size;
        if (off < win) begin
            bank_decode = 3'h1;
        end else if (off < (win << 1)) begin
            bank_decode = 3'h2;
        end else if (off < (win << 1) + ROM_FIXED_WIN) begin
            bank_decode = 3'h4;
        end else begin
            bank_decode = 3'h0;
        end
    endfunction : bank_decode

    sctl_seq_t   state_ff;
    logic [2:0]  sel_n_ff;
    logic        strobe_n_ff;
    logic        ack_ff;
    logic        busy_ff;
    logic [1:0]  idx_ff;
    logic [3:0]  scnt_ff;
    logic [5:0]  acnt_ff;
    logic        sdone_ff;
    logic        adone_ff;

    wire  [2:0]  hit       = bank_decode(addr_off, cfg[SIZE_LSB +: 2]);
    wire         launch    = (state_ff == SEQ_IDLE) && start && (hit != 3'h0);
    wire  [3:0]  next_gap  = cfg[STROBE_GAP_ONE_LSB + 4 * int'(idx_ff) +: 4];

    // counters hold n and fire when they reach zero, giving n+1 cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= SEQ_IDLE;
            sel_n_ff    <= 3'h7;
            strobe_n_ff <= 1'b1;
            ack_ff      <= 1'b0;
            busy_ff     <= 1'b0;
            idx_ff      <= 2'h0;
            scnt_ff     <= 4'h0;
            acnt_ff     <= 6'h0;
            sdone_ff    <= 1'b0;
            adone_ff    <= 1'b0;
        end else begin
            strobe_n_ff <= 1'b1;
            ack_ff      <= 1'b0;
            case (state_ff)
                SEQ_IDLE: begin
                    if (launch) begin
                        state_ff <= SEQ_RUN;
                        busy_ff  <= 1'b1;
                        sel_n_ff <= ~hit;
                        idx_ff   <= 2'h0;
                        scnt_ff  <= cfg[FIRST_LSB +: 4];
                        acnt_ff  <= cfg[ACK_LSB +: 6];
                        sdone_ff <= 1'b0;
                        adone_ff <= 1'b0;
                    end
                end
                SEQ_RUN: begin
                    if (!sdone_ff) begin
                        if (scnt_ff == 4'h0) begin
                            strobe_n_ff <= 1'b0;
                            if (idx_ff == 2'h3) begin
                                sdone_ff <= 1'b1;
                            end else begin
                                idx_ff  <= idx_ff + 2'h1;
                                scnt_ff <= next_gap;
                            end
                        end else begin
                            scnt_ff <= scnt_ff - 4'h1;
                        end
                    end
                    // ack delay runs unchecked against the strobes
                    if (!adone_ff) begin
                        if (acnt_ff == 6'h0) begin
                            ack_ff   <= 1'b1;
                            adone_ff <= 1'b1;
                        end else begin
                            acnt_ff <= acnt_ff - 6'h1;
                        end
                    end
                    if (sdone_ff && adone_ff) begin
                        state_ff <= SEQ_IDLE;
                        busy_ff  <= 1'b0;
                        sel_n_ff <= 3'h7;
                    end
                end
                default: state_ff <= SEQ_IDLE;
            endcase
        end
    end

    assign bank_sel_n = sel_n_ff;
    assign strobe_n   = strobe_n_ff;
    assign block_ack  = ack_ff;
    assign busy       = busy_ff;
endmodule : sctl_rom_seq

//--- sysctl_rom_pio_timer_irq_regs_test.sv
// self-checking bench: controller and register block joined by the link
module sysctl_rom_pio_timer_irq_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sctl_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, se;
    logic        count_event, rom_req, read_data_strobe_n, rom_block_ack, rom_busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sp, ap;
    logic [25:0] src;
    logic [24:0] rom_addr;
    logic [5:0]  pin_out, pin_oe, ext, pv, pd;
    logic [2:0]  boot_bank_select_n, bank;
    logic [31:0] expq[$];
    int          n_errors = 0, comparisons = 0, k, idx;
    wire  [5:0]  pin_w = (pin_oe & pin_out) | (~pin_oe & ext);
    localparam logic [31:0] RA [7] = '{ROM_CFG_ADDR, PIN_VAL_ADDR, PIN_DIR_ADDR, RELOAD_ADDR,
        CNT_CTL_ADDR, MASK_ADDR, PEND_ADDR};
    localparam logic [31:0] RV [7] = '{32'h00ff_ffff, 32'h0, 32'h3f, 32'h0, 32'h0, 32'h0, 32'h0};
    sctl_if link();
    sctl_host sctl_host_i (.clk, .rst_n, .link(link.host), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    sctl_dev sctl_dev_i (.clk, .rst_n, .link(link.dev), .pin_in(pin_w), .pin_out, .pin_oe,
        .count_event, .io_channel_dma_done_irq(src[6:5]), .parport_dma_done_irq(src[7]),
        .parport_reset_irq(src[11]), .parport_write_irq(src[12]), .parport_read_irq(src[13]),
        .byte_match_irq(src[16:14]), .pin_irq(src[25:20]), .rom_req, .rom_addr,
        .boot_bank_select_n, .read_data_strobe_n, .rom_block_ack, .rom_busy);
    sctl_assertions sctl_assertions_i (.clk, .rst_n, .req(link.req), .wr(link.wr),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .irq_n(link.irq_n));
    task automatic wrap_up;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic tmo;
        n_errors++;
        wrap_up;
    endtask : tmo
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one apb transfer; the request holds until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t == 20) tmo;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // launch a link access and poll busy with a bound
    task automatic go(input logic [31:0] c);
        int t;
        apb(1'b1, HOST_CTRL_OFS, c);
        for (t = 0; t < 20; t++) begin
            apb(1'b0, HOST_STAT_OFS, 32'h0);
            if (rd[HOST_BUSY_BIT] === 1'b0) break;
        end
        if (t == 20) tmo;
    endtask : go
    task automatic dw(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, HOST_ADDR_OFS, a);
        apb(1'b1, HOST_WDATA_OFS, d);
        go(32'h3);
    endtask : dw
    task automatic dr(input logic [31:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b1, HOST_ADDR_OFS, a);
        go(32'h1);
    endtask : dr
    // each read answer on the link is matched with the oldest note
    always @(posedge clk) begin
        if (link.ack === 1'b1 && link.req === 1'b1 && link.wr === 1'b0) begin
            chk("rdata", link.rdata, expq.size() > 0 ? expq.pop_front() : 32'hx);
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, count_event, rom_req, rom_addr, src} = '0;
        k = $urandom(90);
        {ext, pv, pd} = 18'($urandom);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 7; k++) dr(RA[k], RV[k]);
        apb(1'b0, 12'h020, 32'h0);
        chk("pslverr", {31'h0, se}, 32'h1);
        dr(32'h1d00_0070, 32'h0);
        dw(PIN_VAL_ADDR, {26'h0, pv});
        dw(PIN_DIR_ADDR, {26'h0, pd});
        dr(SENSE_ADDR, {26'h0, (~pd & pv) | (pd & ext)});
        // pulse every internal source except the timer while pin sources stay high
        src <= 26'h3f1_f8e0;
        @(posedge clk);
        src <= 26'h3f0_0000;
        dr(PEND_ADDR, 32'h03f1_f8e0);
        dw(MASK_ADDR, 32'h03ff_ffff);
        chk("irq_n", {31'h0, link.irq_n}, 32'h0);
        apb(1'b0, HOST_STAT_OFS, 32'h0);
        chk("irq_stat", {31'h0, rd[HOST_IRQ_BIT]}, 32'h1);
        dw(PEND_ADDR, 32'h0);
        dr(PEND_ADDR, 32'h03f0_0000);
        src <= 26'h0;
        dr(PEND_ADDR, 32'h0);
        chk("irq_n", {31'h0, link.irq_n}, 32'h1);
        dw(TEST_SET_ADDR, 32'h03ff_ffff);
        dr(PEND_ADDR, {6'h0, IRQ_INT_BITS});
        dw(MASK_ADDR, 32'h0);
        chk("irq_n", {31'h0, link.irq_n}, 32'h1);
        dw(PEND_ADDR, 32'h0);
        // counter mode: the third event must fire, not the second
        dw(RELOAD_ADDR, 32'h3);
        dw(CNT_CTL_ADDR, 32'h1);
        count_event <= 1'b1;
        repeat (2) @(posedge clk);
        count_event <= 1'b0;
        dr(PEND_ADDR, 32'h0);
        count_event <= 1'b1;
        @(posedge clk);
        count_event <= 1'b0;
        dr(PEND_ADDR, 32'h10);
        dw(CNT_CTL_ADDR, 32'h0);
        dw(PEND_ADDR, 32'h0);
        dw(CNT_CTL_ADDR, 32'h3);
        dr(PEND_ADDR, 32'h10);
        dw(CNT_CTL_ADDR, 32'h0);
        // rom: first 2, gaps 0/1/3, ack 5, 4 MB banks, address in bank 1
        dw(ROM_CFG_ADDR, 32'h0045_3102);
        dr(ROM_CFG_ADDR, 32'h0045_3102);
        apb(1'b0, HOST_RDATA_OFS, 32'h0);
        chk("host_rdata", rd, 32'h0045_3102);
        rom_addr <= 25'h040_0000;
        rom_req <= 1'b1;
        @(posedge clk);
        rom_req <= 1'b0;
        idx = 0;
        sp = 32'h0;
        ap = 32'h0;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (boot_bank_select_n !== 3'h7 && idx < 32) begin
                if (idx == 0) bank = boot_bank_select_n;
                chk("rom_busy", {31'h0, rom_busy}, 32'h1);
                sp[idx] = ~read_data_strobe_n;
                ap[idx] = rom_block_ack;
                idx++;
            end
        end
        chk("bank", {29'h0, bank}, 32'h5);
        chk("strobes", sp, 32'h458);
        chk("block_ack", ap, 32'h40);
        chk("rom_busy_end", {31'h0, rom_busy}, 32'h0);
        chk("notes_left", expq.size(), 32'h0);
        wrap_up;
    end
endmodule : sysctl_rom_pio_timer_irq_regs_test
